/* File: tpc_defines.svh */
// Constants for the two-phase event counter: register offsets, field
// positions, reset values and limits.
// Assumes inclusion by bare name from the package and the modules.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// ****************************************
// Register byte offsets (word aligned)
// ****************************************
`define TPC_OFS_START 8'h00
`define TPC_OFS_MODE 8'h04
`define TPC_OFS_STATUS 8'h08
`define TPC_OFS_MASK 8'h0C
`define TPC_OFS_COUNT2 8'h10
`define TPC_OFS_COUNT3 8'h14
`define TPC_OFS_COUNT4 8'h18

// ****************************************
// Mode register fields
// ****************************************
`define TPC_MODE_QUAD3 0
`define TPC_MODE_ZEN3 1
`define TPC_MODE_ZPOL 2
`define TPC_MODE_FREE_LSB 4
`define TPC_MODE_FREE_MSB 6

// ****************************************
// Reset values and limits
// ****************************************
`define TPC_RST_CTRL 3'h0
`define TPC_RST_MODE 4'h0
`define TPC_RST_COUNT 16'h0000
`define TPC_COUNT_MAX 16'hFFFF
`define TPC_COUNT_MIN 16'h0000
`define TPC_NUM_CH 3

`endif

/* File: tpc_pkg.sv */
// Types shared by the two-phase event counter modules.
// Assumes tpc_defines.svh is on the include path.
package tpc_pkg;
  `include "tpc_defines.svh"

  typedef logic [15:0] tpc_count_type;
  typedef logic [2:0] tpc_chan_type;
  typedef logic [31:0] tpc_word_type;
endpackage : tpc_pkg

/* File: tpc_phase_decode.sv */
// Phase pair synchroniser and edge decoder for one counter channel.
// Assumes raw asynchronous encoder pins and a single timer clock.
`timescale 1ns/1ps
module tpc_phase_decode
  import tpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic primary_i,
  input wire logic secondary_i,
  input wire logic quad_i,
  output logic up_o,
  output logic down_o
);
  logic a_meta_reg;
  logic a_sync_reg;
  logic a_prev_reg;
  logic b_meta_reg;
  logic b_sync_reg;
  logic b_prev_reg;

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_meta_reg <= 1'b0;
      a_sync_reg <= 1'b0;
      a_prev_reg <= 1'b0;
      b_meta_reg <= 1'b0;
      b_sync_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end
    else
    begin
      a_meta_reg <= primary_i;
      a_sync_reg <= a_meta_reg;
      a_prev_reg <= a_sync_reg;
      b_meta_reg <= secondary_i;
      b_sync_reg <= b_meta_reg;
      b_prev_reg <= b_sync_reg;
    end
  end

  // ****************************************
  // Edge decode
  // ****************************************
  wire [1:0] prev_ab = {a_prev_reg, b_prev_reg};
  wire [1:0] cur_ab = {a_sync_reg, b_sync_reg};
  wire a_rise = a_sync_reg & ~a_prev_reg;
  wire a_fall = ~a_sync_reg & a_prev_reg;
  // Normal mode counts primary edges only while secondary is high
  wire norm_up = b_sync_reg & a_rise;
  wire norm_down = b_sync_reg & a_fall;
  // Both pins changing in one sample is illegal quadrature and is ignored
  wire quad_up = (prev_ab == 2'h1 && cur_ab == 2'h3) || (prev_ab == 2'h3 && cur_ab == 2'h2)
    || (prev_ab == 2'h2 && cur_ab == 2'h0) || (prev_ab == 2'h0 && cur_ab == 2'h1);
  wire quad_down = (prev_ab == 2'h3 && cur_ab == 2'h1) || (prev_ab == 2'h2 && cur_ab == 2'h3)
    || (prev_ab == 2'h0 && cur_ab == 2'h2) || (prev_ab == 2'h1 && cur_ab == 2'h0);

  assign up_o = quad_i ? quad_up : norm_up;
  assign down_o = quad_i ? quad_down : norm_down;

  // ****************************************
  // Checks
  // ****************************************
  no_double_a: assert property (@(posedge clk_i) disable iff (rst_i) !(up_o && down_o))
    else $error("up and down asserted together");
  norm_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!quad_i && !b_sync_reg) |-> (!up_o && !down_o))
    else $error("normal mode counted with secondary low");
endmodule : tpc_phase_decode

/* File: tpc_top.sv */
// Three-channel two-phase event counter with a classic Wishbone slave.
// Assumes encoder pins are asynchronous and software is the only bus master.
`timescale 1ns/1ps
module tpc_top
  import tpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [2:0] primary_phase_pin_i,
  input wire logic [2:0] secondary_phase_pin_i,
  input wire logic z_phase_i
);

  // ****************************************
  // Functions
  // ****************************************
  // Returns {wrap flag, next count} for one count event
  function automatic logic [16:0] cnt_step(input tpc_count_type c, input tpc_count_type r,
    input logic up, input logic free, input logic zclr);
    tpc_count_type nxt;
    logic wrap;
    nxt = c;
    wrap = 1'b0;
    if (up)
    begin
      if (c == `TPC_COUNT_MAX)
      begin
        wrap = 1'b1;
        nxt = free ? `TPC_COUNT_MIN : r;
      end
      else
      begin
        nxt = c + 16'h0001;
      end
    end
    else
    begin
      if (c == `TPC_COUNT_MIN)
      begin
        wrap = 1'b1;
        nxt = free ? `TPC_COUNT_MAX : r;
      end
      else
      begin
        nxt = c - 16'h0001;
      end
    end
    // A clear that meets a wrap still reports the wrap
    if (zclr)
    begin
      nxt = `TPC_COUNT_MIN;
    end
    return {wrap, nxt};
  endfunction : cnt_step

  // Byte-lane merge of a 16-bit register
  function automatic tpc_count_type merge16(input tpc_count_type old, input logic [31:0] d,
    input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ****************************************
  // State
  // ****************************************
  tpc_chan_type run_reg;
  tpc_chan_type free_reg;
  logic quad3_reg;
  logic zen3_reg;
  logic zpol_reg;
  tpc_chan_type status_reg;
  tpc_chan_type mask_reg;
  tpc_chan_type started_reg;
  tpc_count_type count_reg [`TPC_NUM_CH];
  tpc_count_type reload_reg [`TPC_NUM_CH];
  logic ack_reg;
  tpc_word_type dat_reg;
  logic irq_reg;
  logic z_meta_reg;
  logic z_sync_reg;
  logic z_prev_reg;
  logic z_pend_reg;

  tpc_chan_type started_next;
  tpc_chan_type wrap_flag;
  tpc_count_type count_next [`TPC_NUM_CH];
  tpc_count_type reload_next [`TPC_NUM_CH];
  tpc_chan_type up_evt;
  tpc_chan_type down_evt;

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr = bus_req & wb_we_i;
  wire lane0 = wb_sel_i[0];
  wire hit_start = wb_adr_i == `TPC_OFS_START;
  wire hit_mode = wb_adr_i == `TPC_OFS_MODE;
  wire hit_status = wb_adr_i == `TPC_OFS_STATUS;
  wire hit_mask = wb_adr_i == `TPC_OFS_MASK;
  wire hit_cnt2 = wb_adr_i == `TPC_OFS_COUNT2;
  wire hit_cnt3 = wb_adr_i == `TPC_OFS_COUNT3;
  wire hit_cnt4 = wb_adr_i == `TPC_OFS_COUNT4;
  wire wr_start = bus_wr & hit_start & lane0;
  wire wr_mode = bus_wr & hit_mode & lane0;
  wire wr_status = bus_wr & hit_status & lane0;
  wire wr_mask = bus_wr & hit_mask & lane0;
  wire [2:0] cnt_wr = {3{bus_wr}} & {hit_cnt4, hit_cnt3, hit_cnt2} & {3{|wb_sel_i[1:0]}};

  wire [7:0] mode_word = {1'b0, free_reg, 1'b0, zpol_reg, zen3_reg, quad3_reg};
  // Unmapped offsets read as zero and are still acknowledged
  wire [31:0] rd_word = hit_start ? {29'h0, run_reg}
    : hit_mode ? {24'h0, mode_word}
    : hit_status ? {29'h0, status_reg}
    : hit_mask ? {29'h0, mask_reg}
    : hit_cnt2 ? {16'h0, count_reg[0]}
    : hit_cnt3 ? {16'h0, count_reg[1]}
    : hit_cnt4 ? {16'h0, count_reg[2]}
    : 32'h00000000;

  // ****************************************
  // Phase decoders
  // ****************************************
  // Channel 2 is fixed normal, channel 4 fixed quad
  wire [2:0] quad_sel = {1'b1, quad3_reg, 1'b0};

  for (genvar g = 0; g < `TPC_NUM_CH; g++)
  begin : g_dec
    tpc_phase_decode u_dec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .primary_i(primary_phase_pin_i[g]),
      .secondary_i(secondary_phase_pin_i[g]),
      .quad_i(quad_sel[g]),
      .up_o(up_evt[g]),
      .down_o(down_evt[g])
    );
  end

  wire [2:0] cnt_evt = run_reg & (up_evt | down_evt);

  // ****************************************
  // Z index
  // ****************************************
  wire z_rise = z_sync_reg & ~z_prev_reg;
  wire z_fall = ~z_sync_reg & z_prev_reg;
  wire z_edge = zen3_reg & run_reg[1] & (zpol_reg ? z_fall : z_rise);
  // Index is remembered and only acted on at the next count event
  wire z_pend_next = z_edge | (z_pend_reg & ~cnt_evt[1]);
  wire [2:0] zclr = {1'b0, z_pend_reg, 1'b0};

  // ****************************************
  // Counter next state
  // ****************************************
  always_comb
  begin
    logic [16:0] step;
    tpc_count_type wval;
    step = 17'h00000;
    wval = `TPC_RST_COUNT;
    for (int i = 0; i < `TPC_NUM_CH; i++)
    begin
      count_next[i] = count_reg[i];
      reload_next[i] = reload_reg[i];
      wrap_flag[i] = 1'b0;
      started_next[i] = run_reg[i] & (started_reg[i] | cnt_evt[i]);
      step = cnt_step(count_reg[i], reload_reg[i], up_evt[i], free_reg[i], zclr[i]);
      wval = merge16(reload_reg[i], wb_dat_i, wb_sel_i);
      if (cnt_evt[i])
      begin
        count_next[i] = step[15:0];
        wrap_flag[i] = step[16];
      end
      if (cnt_wr[i])
      begin
        reload_next[i] = wval;
        if (!run_reg[i] || !started_reg[i])
        begin
          count_next[i] = wval;
        end
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  wire [2:0] status_clr = wr_status ? wb_dat_i[2:0] : 3'h0;
  wire [2:0] status_next = (status_reg & ~status_clr) | wrap_flag;
  wire [2:0] mask_next = wr_mask ? wb_dat_i[2:0] : mask_reg;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_reg <= `TPC_RST_CTRL;
      free_reg <= `TPC_RST_CTRL;
      quad3_reg <= 1'b0;
      zen3_reg <= 1'b0;
      zpol_reg <= 1'b0;
      mask_reg <= `TPC_RST_CTRL;
    end
    else
    begin
      if (wr_start)
      begin
        run_reg <= wb_dat_i[2:0];
      end
      if (wr_mode)
      begin
        quad3_reg <= wb_dat_i[`TPC_MODE_QUAD3];
        zen3_reg <= wb_dat_i[`TPC_MODE_ZEN3];
        zpol_reg <= wb_dat_i[`TPC_MODE_ZPOL];
        free_reg <= wb_dat_i[`TPC_MODE_FREE_MSB:`TPC_MODE_FREE_LSB];
      end
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_reg <= `TPC_RST_CTRL;
      started_reg <= `TPC_RST_CTRL;
      irq_reg <= 1'b0;
      z_meta_reg <= 1'b0;
      z_sync_reg <= 1'b0;
      z_prev_reg <= 1'b0;
      z_pend_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      started_reg <= started_next;
      irq_reg <= |(status_next & mask_next);
      z_meta_reg <= z_phase_i;
      z_sync_reg <= z_meta_reg;
      z_prev_reg <= z_sync_reg;
      z_pend_reg <= z_pend_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < `TPC_NUM_CH; i++)
    begin
      if (rst_i)
      begin
        count_reg[i] <= `TPC_RST_COUNT;
        reload_reg[i] <= `TPC_RST_COUNT;
      end
      else
      begin
        count_reg[i] <= count_next[i];
        reload_reg[i] <= reload_next[i];
      end
    end
  end

  // One wait state: answer always lands one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_word : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;

  // ****************************************
  // Checks
  // ****************************************
  bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> (ack_reg ##1 !ack_reg))
    else $error("bus ack not a single pulse after request");

  stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run_reg[0] && !cnt_wr[0]) |=> count_reg[0] == $past(count_reg[0]))
    else $error("stopped channel count changed");

  wrap_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_flag[0] && mask_reg[0] && !wr_mask) |=> (status_reg[0] && irq_o))
    else $error("wrap did not raise interrupt");

  ovf_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_evt[0] && up_evt[0] && count_reg[0] == 16'hFFFF && !free_reg[0] && !cnt_wr[0])
    |=> count_reg[0] == $past(reload_reg[0]))
    else $error("overflow did not reload");

  free_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_evt[2] && down_evt[2] && count_reg[2] == 16'h0000 && free_reg[2] && !cnt_wr[2])
    |=> count_reg[2] == 16'hFFFF)
    else $error("free-run underflow did not wrap");

  count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_evt[0] && up_evt[0] && count_reg[0] != 16'hFFFF && !cnt_wr[0])
    |=> count_reg[0] == $past(count_reg[0]) + 16'h0001)
    else $error("up event did not increment");

  early_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_wr[1] && !started_reg[1] && wb_sel_i[1:0] == 2'h3)
    |=> (count_reg[1] == $past(wb_dat_i[15:0]) && reload_reg[1] == count_reg[1]))
    else $error("early write did not load counter");

  late_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_wr[0] && started_reg[0] && run_reg[0] && !cnt_evt[0])
    |=> count_reg[0] == $past(count_reg[0]))
    else $error("running write disturbed counter");

  z_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (z_pend_reg && cnt_evt[1] && !cnt_wr[1]) |=> count_reg[1] == 16'h0000)
    else $error("index clear not applied");

  z_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (z_edge && !cnt_evt[1]) |=> z_pend_reg)
    else $error("index edge lost");

  live_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !wb_we_i && hit_cnt4) |=> wb_dat_o[15:0] == $past(count_reg[2]))
    else $error("count read not live");
endmodule : tpc_top

/* File: tpc_encoder_model.sv */
// Behavioural incremental encoder driving the three phase pairs and the Z index.
// Assumes one timer clock; pins change just after a rising edge only.
`timescale 1ns/1ps
module tpc_encoder_model
  import tpc_pkg::*;
(
  input wire logic clk_i,
  output logic [2:0] primary_o,
  output logic [2:0] secondary_o,
  output logic z_o
);
  // ****************************************
  // Quadrature position per channel
  // ****************************************
  logic [1:0] pos_reg [3];

  initial
  begin
    primary_o = 3'h0;
    secondary_o = 3'h7;
    z_o = 1'h0;
    pos_reg = '{2'h0, 2'h0, 2'h0};
  end

  // Gray order (A,B): 01, 11, 10, 00 counts up
  function automatic logic [1:0] phase_of(input logic [1:0] pos);
    begin
      case (pos)
        2'h0: phase_of = 2'h1;
        2'h1: phase_of = 2'h3;
        2'h2: phase_of = 2'h2;
        default: phase_of = 2'h0;
      endcase
    end
  endfunction : phase_of

  // ****************************************
  // Steps and index pulse
  // ****************************************
  // One pin changes per step and then holds long enough to be sampled
  task automatic step(input int ch, input logic up);
    logic [1:0] ab;
    begin
      pos_reg[ch] = up ? pos_reg[ch] + 2'h1 : pos_reg[ch] - 2'h1;
      ab = phase_of(pos_reg[ch]);
      @(posedge clk_i);
      primary_o[ch] <= ab[1];
      secondary_o[ch] <= ab[0];
      repeat (5) @(posedge clk_i);
    end
  endtask : step

  task automatic z_pulse();
    begin
      @(posedge clk_i);
      z_o <= 1'h1;
      repeat (5) @(posedge clk_i);
      z_o <= 1'h0;
      repeat (5) @(posedge clk_i);
    end
  endtask : z_pulse
endmodule : tpc_encoder_model

/* File: testbench.sv */
// Self-checking bench: Wishbone register calls plus encoder steps.
// Assumes the encoder model and the counter top share one 25 MHz clock.
`timescale 1ns/1ps
module testbench
  import tpc_pkg::*;
;
  `include "tpc_defines.svh"
  logic clk = 1'h0;
  logic rst, cyc, stb, we, ack, irq, z;
  logic [7:0] adr;
  logic [3:0] sel;
  tpc_word_type wdat, rdat, q;
  logic [2:0] pa, pb;
  int miscompares = 0;
  int checks = 0;

  always #20 clk <= ~clk;

  tpc_top i_tpc_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .primary_phase_pin_i(pa), .secondary_phase_pin_i(pb),
    .z_phase_i(z));
  tpc_encoder_model i_tpc_encoder_model (.clk_i(clk), .primary_o(pa), .secondary_o(pb),
    .z_o(z));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input tpc_word_type got, input tpc_word_type exp);
    begin
      checks++;
      if (got !== exp)
      begin
        miscompares++;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask : chk

  // Request held until ack is sampled; slave latency is not assumed
  task automatic wb(input logic w, input logic [7:0] a, input tpc_word_type d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (ack !== 1'h1 && n < 50);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      if (n >= 50)
        chk(32'h0000DEAD, 32'h00000000);
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input tpc_word_type d);
    wb(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input tpc_word_type e);
    begin
      wb(1'h0, a, 32'h0);
      chk(q, e);
    end
  endtask : rd

  task automatic irq_is(input logic e);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  task automatic st(input int ch, input logic up, input int n);
    repeat (n) i_tpc_encoder_model.step(ch, up);
  endtask : st

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task end_of_test();
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : end_of_test

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    rst <= 1'h1;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    adr <= 8'h00;
    sel <= 4'hF;
    wdat <= 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rd(`TPC_OFS_COUNT2, 32'h0);
    rd(`TPC_OFS_STATUS, 32'h0);
    rd(8'h1C, 32'h0);
    irq_is(1'h0);
    done("reset");
    wr(`TPC_OFS_COUNT2, 32'h0000FFFE);
    st(0, 1'h1, 1);
    st(0, 1'h0, 1);
    rd(`TPC_OFS_COUNT2, 32'h0000FFFE);
    done("stopped");
    wr(`TPC_OFS_MASK, 32'h1);
    wr(`TPC_OFS_START, 32'h1);
    st(0, 1'h1, 1);
    rd(`TPC_OFS_COUNT2, 32'h0000FFFF);
    wr(`TPC_OFS_COUNT2, 32'h00001234);
    rd(`TPC_OFS_COUNT2, 32'h0000FFFF);
    // Normal mode ignores the other three quadrature transitions
    st(0, 1'h1, 3);
    rd(`TPC_OFS_COUNT2, 32'h0000FFFF);
    irq_is(1'h0);
    st(0, 1'h1, 1);
    rd(`TPC_OFS_COUNT2, 32'h00001234);
    rd(`TPC_OFS_STATUS, 32'h1);
    irq_is(1'h1);
    wr(`TPC_OFS_MASK, 32'h0);
    irq_is(1'h0);
    wr(`TPC_OFS_MASK, 32'h1);
    irq_is(1'h1);
    wr(`TPC_OFS_STATUS, 32'h1);
    irq_is(1'h0);
    rd(`TPC_OFS_STATUS, 32'h0);
    // Only the first of four down steps drops primary while secondary is high
    st(0, 1'h0, 4);
    rd(`TPC_OFS_COUNT2, 32'h00001233);
    done("channel2");
    wr(`TPC_OFS_COUNT4, 32'h00000002);
    wr(`TPC_OFS_START, 32'h5);
    st(2, 1'h0, 2);
    rd(`TPC_OFS_COUNT4, 32'h00000000);
    rd(`TPC_OFS_STATUS, 32'h0);
    st(2, 1'h0, 1);
    rd(`TPC_OFS_COUNT4, 32'h00000002);
    rd(`TPC_OFS_STATUS, 32'h4);
    st(2, 1'h1, 1);
    rd(`TPC_OFS_COUNT4, 32'h00000003);
    wr(`TPC_OFS_STATUS, 32'h4);
    // Free-running channel 4 wraps from zero to all ones
    wr(`TPC_OFS_MODE, 32'h40);
    st(2, 1'h0, 4);
    rd(`TPC_OFS_COUNT4, 32'h0000FFFF);
    rd(`TPC_OFS_STATUS, 32'h4);
    wr(`TPC_OFS_STATUS, 32'h4);
    done("channel4");
    wr(`TPC_OFS_COUNT3, 32'h0000FFFE);
    wr(`TPC_OFS_START, 32'h7);
    st(1, 1'h1, 2);
    rd(`TPC_OFS_COUNT3, 32'h0000FFFF);
    wr(`TPC_OFS_START, 32'h5);
    wr(`TPC_OFS_MODE, 32'h1);
    wr(`TPC_OFS_COUNT3, 32'h0000FFFE);
    wr(`TPC_OFS_START, 32'h7);
    st(1, 1'h1, 2);
    rd(`TPC_OFS_COUNT3, 32'h0000FFFE);
    rd(`TPC_OFS_STATUS, 32'h2);
    wr(`TPC_OFS_MODE, 32'h21);
    st(1, 1'h1, 2);
    rd(`TPC_OFS_COUNT3, 32'h00000000);
    wr(`TPC_OFS_MODE, 32'h23);
    st(1, 1'h1, 3);
    i_tpc_encoder_model.z_pulse();
    rd(`TPC_OFS_COUNT3, 32'h00000003);
    st(1, 1'h1, 1);
    rd(`TPC_OFS_COUNT3, 32'h00000000);
    // Falling index polarity
    wr(`TPC_OFS_MODE, 32'h27);
    st(1, 1'h1, 2);
    i_tpc_encoder_model.z_pulse();
    rd(`TPC_OFS_COUNT3, 32'h00000002);
    st(1, 1'h1, 1);
    rd(`TPC_OFS_COUNT3, 32'h00000000);
    done("channel3");
    wr(`TPC_OFS_START, 32'h0);
    st(2, 1'h1, 1);
    rd(`TPC_OFS_COUNT4, 32'h0000FFFF);
    done("stop");
    end_of_test();
  end

  // Whole sequence needs well under 2000 cycles; allow 10000
  initial
  begin
    #400000;
    miscompares++;
    end_of_test();
  end
endmodule : testbench
